// ### hdl/aws_pkg.sv
// Shared constants and types of the arbitrary waveform sequencer
package aws_pkg;

  // Clock and sample timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned SAMPLE_US = 10;
  localparam int unsigned SAMPLE_CYCLES = CLK_HZ / US_PER_S * SAMPLE_US;
  localparam int unsigned RAMP_UNIT_US = 100;

  // Widths
  localparam int unsigned AMP_W = 16;
  localparam int unsigned FREQ_W = 14;
  localparam int unsigned PH_W = 9;
  localparam int unsigned TIME_W = 36;
  localparam int unsigned RT_W = 29;
  localparam int unsigned CYC_W = 10;
  localparam int unsigned PT_W = 7;
  localparam int unsigned FRAC_W = 16;
  localparam int unsigned NUM_POINTS = 99;

  // Value limits
  localparam logic [31:0] FREQ_MAX = 32'h0000_2710;
  localparam logic [31:0] PHASE_MAX = 32'h0000_0167;
  localparam logic [35:0] TIME_MIN_US = 36'h0_0000_0064;
  localparam logic [35:0] TIME_MAX_US = 36'h8_61c4_6800;
  localparam logic [31:0] CYC_MAX = 32'h0000_03e7;
  localparam logic [31:0] RAMP_T_MIN = 32'h0000_0001;
  localparam logic [31:0] RAMP_T_MAX = 32'h1575_2a00;

  // Phase accumulator scaling, full circle is 2^32
  localparam logic [31:0] PHASE_PER_HZ = 32'(64'h1_0000_0000 * SAMPLE_US / US_PER_S);
  localparam logic [31:0] PHASE_PER_DEG = 32'(64'h1_0000_0000 / 360);
  localparam logic [15:0] SIN_C0 = 16'hc666;
  localparam logic [15:0] SIN_C1 = 16'h399a;

  // Register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_SEQ_CFG = 12'h008;
  localparam logic [11:0] OFF_RAMP_START = 12'h00c;
  localparam logic [11:0] OFF_RAMP_END = 12'h010;
  localparam logic [11:0] OFF_RAMP_DELAY = 12'h014;
  localparam logic [11:0] OFF_RAMP_DUR = 12'h018;
  localparam logic [11:0] OFF_LOAD_CTRL = 12'h01c;
  localparam logic [11:0] OFF_LOAD_DATA = 12'h020;
  localparam logic [11:0] OFF_LOAD_EXT = 12'h024;
  localparam logic [11:0] OFF_LOAD_SEP = 12'h028;
  localparam logic [11:0] OFF_NAME_LO = 12'h02c;
  localparam logic [11:0] OFF_NAME_HI = 12'h030;
  localparam logic [11:0] OFF_EXP_DATA = 12'h034;
  localparam logic [11:0] OFF_SET_VALUE = 12'h038;

  // Field positions
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_STOP = 1;
  localparam int unsigned CTRL_RAMP = 2;
  localparam int unsigned CTRL_CURRENT = 3;
  localparam int unsigned CTRL_SEP_FMT = 4;
  localparam int unsigned LD_BEGIN = 0;
  localparam int unsigned LD_COMMIT = 1;
  localparam int unsigned LD_EXPORT = 2;
  localparam int unsigned SEQ_LAST_LSB = 8;
  localparam int unsigned SEQ_CYC_LSB = 16;
  localparam int unsigned EXP_COLS = 9;

  // Characters
  localparam logic [7:0] CHR_SEMI = 8'h3b;
  localparam logic [7:0] CHR_COMMA = 8'h2c;
  localparam logic [7:0] CHR_DOT = 8'h2e;
  localparam logic [31:0] CHR_WAVE = 32'h4556_4157;
  localparam logic [7:0] CHR_SPACE = 8'h20;
  localparam logic [7:0] CHR_UNDER = 8'h5f;
  localparam logic [7:0] CHR_U = 8'h55;
  localparam logic [7:0] CHR_I = 8'h49;
  localparam logic [7:0] CHR_UPPER = 8'hdf;

  typedef struct packed {
    logic [AMP_W-1:0] ac_s;
    logic [AMP_W-1:0] ac_e;
    logic [FREQ_W-1:0] f_s;
    logic [FREQ_W-1:0] f_e;
    logic [PH_W-1:0] ph;
    logic [AMP_W-1:0] dc_s;
    logic [AMP_W-1:0] dc_e;
    logic [TIME_W-1:0] dur;
  } aws_point_s;

endpackage : aws_pkg

// ### hdl/aws_div_if.sv
// Request and answer signals of the fraction divider
interface aws_div_if #(
  parameter int unsigned NUM_W = 36,
  parameter int unsigned QW = 17
);
  logic start;
  logic [NUM_W-1:0] num;
  logic [NUM_W-1:0] den;
  logic busy;
  logic done;
  logic [QW-1:0] quo;
  modport master (output start, output num, output den, input busy, input done, input quo);
  modport slave (input start, input num, input den, output busy, output done, output quo);
endinterface : aws_div_if

// ### hdl/aws_div.sv
// Serial divider giving num/den as a fraction with QW-1 fraction bits
module aws_div #(
  parameter int unsigned NUM_W = 36,
  parameter int unsigned QW = 17
) (
  // Clock and reset
  input logic core_clk,
  input logic rst_n,
  // Request and answer
  aws_div_if.slave d
);

  typedef struct packed {
    logic [NUM_W+1:0] rem;
    logic [NUM_W-1:0] den;
    logic [QW-1:0] quo;
    logic [5:0] cnt;
    logic busy;
    logic done;
  } aws_div_s;

  aws_div_s q;
  aws_div_s n;

  always_comb
  begin
    logic bit_v;
    logic [NUM_W+1:0] r;
    bit_v = 1'b0;
    r = '0;
    n = q;
    n.done = 1'b0;
    if (d.start && !q.busy)
    begin
      n.rem = {2'b00, d.num};
      n.den = d.den;
      n.quo = '0;
      n.cnt = 6'(QW);
      n.busy = 1'b1;
    end
    else if (q.busy)
    begin
      bit_v = q.rem >= {2'b00, q.den};
      r = bit_v ? q.rem - {2'b00, q.den} : q.rem;
      n.rem = {r[NUM_W:0], 1'b0};
      n.quo = {q.quo[QW-2:0], bit_v};
      n.cnt = q.cnt - 6'd1;
      if (q.cnt == 6'd1)
      begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= n;
  end

  assign d.busy = q.busy;
  assign d.done = q.done;
  assign d.quo = q.quo;

endmodule : aws_div

// ### hdl/aws_top.sv
// Arbitrary waveform sequencer and single-shot ramp generator with APB registers
// Notes on behaviour
// - Nonzero frequency gives a sine of set amplitude around the point's DC level.
// - Periods per point follow duration times frequency; fractions allowed.
// - Sine amplitude moves linearly from AC start to AC end over the point.
// - DC offset moves linearly from DC start to DC end over the point.
// - Each point's sine starts at its phase, 0 to 359 degrees in 1 degree steps.
// - Differing start and end frequencies sweep the sine frequency across the point.
// - Both frequencies zero gives no AC part, only the DC ramp.
// - Points of the block run one after another in order.
// - Up to 99 points, all on voltage or all on current.
// - Each repeated cycle restarts points at their start levels, jumps allowed.
// - Column and decimal separators must match the file format setting.
// - A table is checked before loading; on error the old table stays.
// - Only files named for the selected quantity, case-insensitive, are offered.
// - Import and export always move the whole 99-point table.
// - The ramp waits a delay of 0.1 ms to 36,000,000 ms before starting.
// - After the delay the ramp moves linearly from start to end over its duration.
// - Ramp start and end lie between zero and the nominal rating.
// - The ramp runs once and then holds the end value.
// - The block repeats for up to 999 cycles, zero meaning endless.
//
// Design decisions made here: register access over APB and the placing of the registers.
module aws_top import aws_pkg::*; #(
  parameter logic [15:0] NOM_VALUE = 16'hffff
) (
  // Clock and reset
  input logic core_clk,
  input logic rst_n,
  // APB slave
  input logic [11:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Source side
  input logic output_on,
  output logic [15:0] set_value,
  output logic target_current,
  output logic gen_active
);

  typedef enum logic {SQ_IDLE, SQ_RUN} aws_seq_e;
  typedef enum logic [1:0] {RP_IDLE, RP_DELAY, RP_SLOPE, RP_HOLD} aws_ramp_e;

  typedef struct packed {
    logic on1;
    logic on2;
    logic func_ramp;
    logic target_cur;
    logic sep_fmt;
    logic [PT_W-1:0] pt_first;
    logic [PT_W-1:0] pt_last;
    logic [CYC_W-1:0] cycles;
    logic [AMP_W-1:0] r_start;
    logic [AMP_W-1:0] r_end;
    logic [RT_W-1:0] r_delay;
    logic [RT_W-1:0] r_dur;
    aws_point_s [NUM_POINTS-1:0] tbl;
    aws_point_s [NUM_POINTS:0] stg;
    logic ld_active;
    logic ld_err;
    logic sep_ok;
    logic [PT_W-1:0] ld_row;
    logic [2:0] ld_col;
    logic [3:0] ld_ext;
    logic [PT_W-1:0] exp_row;
    logic [3:0] exp_col;
    logic [47:0] name;
    aws_seq_e seq;
    aws_ramp_e ramp;
    logic [PT_W-1:0] cur;
    logic [PT_W-1:0] sp;
    logic [CYC_W-1:0] cyc;
    logic [8:0] tick;
    logic [TIME_W-1:0] elapsed;
    logic [TIME_W-1:0] sn;
    logic [31:0] phase;
    logic [31:0] sph;
    logic [FREQ_W-1:0] freq;
    logic [TIME_W-1:0] r_el;
    logic go0;
    logic go1;
    logic [15:0] set_q;
    logic [31:0] prdata;
  } aws_state_s;

  aws_state_s q;
  aws_state_s n;

  aws_div_if #(.NUM_W(TIME_W), .QW(FRAC_W + 1)) d0 ();
  aws_div_if #(.NUM_W(TIME_W), .QW(FRAC_W + 1)) d1 ();

  aws_div #(.NUM_W(TIME_W), .QW(FRAC_W + 1)) u_div_seq (.core_clk(core_clk), .rst_n(rst_n), .d(d0));
  aws_div #(.NUM_W(TIME_W), .QW(FRAC_W + 1)) u_div_ramp (.core_clk(core_clk), .rst_n(rst_n), .d(d1));

  function automatic logic [15:0] lerp(input logic [15:0] a, input logic [15:0] b, input logic [16:0] f);
    logic signed [34:0] t;
    t = 35'(($signed({1'b0, b}) - $signed({1'b0, a})) * $signed({1'b0, f}));
    lerp = 16'($signed({19'd0, a}) + (t >>> FRAC_W));
  endfunction : lerp

  // Two-term fit of a half sine; worst error is near 0.1 percent of full scale
  function automatic logic [15:0] sine_mag(input logic [31:0] ph);
    logic [15:0] x;
    logic [31:0] pr;
    logic [16:0] y;
    logic [32:0] c;
    logic [49:0] s;
    x = ph[30:15];
    pr = 32'(x) * (32'h0001_0000 - 32'(x));
    y = 17'(pr >> 14);
    c = 33'(SIN_C0) + 33'((33'(y) * 33'(SIN_C1)) >> 16);
    s = (50'(y) * 50'(c)) >> 16;
    sine_mag = (s > 50'hffff) ? 16'hffff : s[15:0];
  endfunction : sine_mag

  function automatic logic [31:0] get_col(input aws_point_s p, input logic [3:0] c);
    case (c)
      4'd0: get_col = 32'(p.ac_s);
      4'd1: get_col = 32'(p.ac_e);
      4'd2: get_col = 32'(p.f_s);
      4'd3: get_col = 32'(p.f_e);
      4'd4: get_col = 32'(p.ph);
      4'd5: get_col = 32'(p.dc_s);
      4'd6: get_col = 32'(p.dc_e);
      4'd7: get_col = p.dur[31:0];
      4'd8: get_col = 32'(p.dur[35:32]);
      default: get_col = '0;
    endcase
  endfunction : get_col

  always_comb
  begin
    aws_point_s p;
    aws_point_s np;
    logic smp;
    logic acc;
    logic wr;
    logic valid;
    logic running;
    logic name_ok;
    logic ok;
    logic [7:0] want_sep;
    logic [7:0] want_dec;
    logic [16:0] frac;
    logic [15:0] amp;
    logic [15:0] dcv;
    logic [15:0] frv;
    logic [15:0] mag;
    logic signed [17:0] vs;
    logic [35:0] hv;
    logic [PT_W-1:0] nxt;
    logic [31:0] rd;
    p = '0;
    np = '0;
    ok = 1'b0;
    frac = '0;
    amp = '0;
    dcv = '0;
    frv = '0;
    mag = '0;
    vs = '0;
    hv = '0;
    nxt = '0;
    n = q;
    n.on1 = output_on;
    n.on2 = q.on1;
    n.go0 = 1'b0;
    n.go1 = 1'b0;
    smp = q.tick == 9'(SAMPLE_CYCLES - 1);
    n.tick = smp ? 9'd0 : q.tick + 9'd1;
    running = q.seq == SQ_RUN || q.ramp == RP_DELAY || q.ramp == RP_SLOPE;
    name_ok = q.name[31:0] == (q.name[31:0] & {4{CHR_UPPER}}) ? q.name[31:0] == CHR_WAVE
              : (q.name[31:0] & {4{CHR_UPPER}}) == CHR_WAVE;
    name_ok = name_ok && (q.name[39:32] == CHR_SPACE || q.name[39:32] == CHR_UNDER)
              && (q.name[47:40] & CHR_UPPER) == (q.target_cur ? CHR_I : CHR_U);
    want_sep = q.sep_fmt ? CHR_COMMA : CHR_SEMI;
    want_dec = q.sep_fmt ? CHR_DOT : CHR_COMMA;
    acc = psel && penable;
    wr = acc && pwrite && pstrb == 4'hf;
    case (paddr)
      OFF_CTRL, OFF_STATUS, OFF_SEQ_CFG, OFF_RAMP_START, OFF_RAMP_END, OFF_RAMP_DELAY, OFF_RAMP_DUR,
      OFF_LOAD_CTRL, OFF_LOAD_DATA, OFF_LOAD_EXT, OFF_LOAD_SEP, OFF_NAME_LO, OFF_NAME_HI, OFF_EXP_DATA,
      OFF_SET_VALUE: valid = 1'b1;
      default: valid = 1'b0;
    endcase
    case (paddr)
      OFF_CTRL: rd = 32'({q.sep_fmt, q.target_cur, q.func_ramp, 2'b00});
      OFF_STATUS: rd = {6'd0, q.cyc, 1'b0, 7'(q.cur + 7'd1), 2'b00, q.on2, name_ok, q.ld_err, q.ld_active,
                        q.ramp == RP_DELAY || q.ramp == RP_SLOPE, q.seq == SQ_RUN};
      OFF_SEQ_CFG: rd = {6'd0, q.cycles, 1'b0, 7'(q.pt_last + 7'd1), 1'b0, 7'(q.pt_first + 7'd1)};
      OFF_RAMP_START: rd = 32'(q.r_start);
      OFF_RAMP_END: rd = 32'(q.r_end);
      OFF_RAMP_DELAY: rd = 32'(q.r_delay);
      OFF_RAMP_DUR: rd = 32'(q.r_dur);
      OFF_NAME_LO: rd = q.name[31:0];
      OFF_NAME_HI: rd = 32'(q.name[47:32]);
      OFF_EXP_DATA: rd = (q.exp_row < 7'(NUM_POINTS)) ? get_col(q.tbl[q.exp_row], q.exp_col) : '0;
      OFF_SET_VALUE: rd = 32'(q.set_q);
      default: rd = '0;
    endcase
    if (psel && !penable && !pwrite)
      n.prdata = rd;
    pslverr = acc && (!valid || (pwrite && pstrb != 4'hf));
    // Register writes
    if (wr)
    begin
      case (paddr)
        OFF_CTRL:
        begin
          n.sep_fmt = pwdata[CTRL_SEP_FMT];
          if (!running)
          begin
            n.func_ramp = pwdata[CTRL_RAMP];
            n.target_cur = pwdata[CTRL_CURRENT];
          end
        end
        OFF_SEQ_CFG:
        begin
          if (pwdata[6:0] != 7'd0 && pwdata[14:8] >= pwdata[6:0] && pwdata[14:8] <= 7'(NUM_POINTS)
              && 32'(pwdata[25:16]) <= CYC_MAX)
          begin
            n.pt_first = pwdata[6:0] - 7'd1;
            n.pt_last = pwdata[14:8] - 7'd1;
            n.cycles = pwdata[25:16];
          end
        end
        OFF_RAMP_START: n.r_start = (pwdata > 32'(NOM_VALUE)) ? NOM_VALUE : pwdata[15:0];
        OFF_RAMP_END: n.r_end = (pwdata > 32'(NOM_VALUE)) ? NOM_VALUE : pwdata[15:0];
        OFF_RAMP_DELAY: n.r_delay = (pwdata < RAMP_T_MIN) ? RAMP_T_MIN[RT_W-1:0]
                                   : (pwdata > RAMP_T_MAX) ? RAMP_T_MAX[RT_W-1:0] : pwdata[RT_W-1:0];
        OFF_RAMP_DUR: n.r_dur = (pwdata < RAMP_T_MIN) ? RAMP_T_MIN[RT_W-1:0]
                                 : (pwdata > RAMP_T_MAX) ? RAMP_T_MAX[RT_W-1:0] : pwdata[RT_W-1:0];
        OFF_NAME_LO: n.name[31:0] = pwdata;
        OFF_NAME_HI: n.name[47:32] = pwdata[15:0];
        OFF_LOAD_EXT: n.ld_ext = pwdata[3:0];
        OFF_LOAD_SEP:
        begin
          n.sep_ok = pwdata[7:0] == want_sep && pwdata[15:8] == want_dec;
          if (!n.sep_ok)
            n.ld_err = 1'b1;
        end
        OFF_LOAD_CTRL:
        begin
          if (pwdata[LD_BEGIN])
          begin
            n.ld_active = !q.on2 && name_ok && !running;
            n.ld_err = !n.ld_active;
            n.sep_ok = 1'b0;
            n.ld_row = '0;
            n.ld_col = '0;
          end
          else if (pwdata[LD_COMMIT] && q.ld_active)
          begin
            n.ld_active = 1'b0;
            if ((q.ld_row == 7'(NUM_POINTS) || q.ld_row == 7'(NUM_POINTS + 1)) && q.ld_col == 3'd0
                && !q.ld_err && q.sep_ok)
              n.tbl = q.stg[NUM_POINTS-1:0];
            else
              n.ld_err = 1'b1;
          end
          if (pwdata[LD_EXPORT] && !q.on2)
          begin
            n.exp_row = '0;
            n.exp_col = '0;
          end
        end
        OFF_LOAD_DATA:
        begin
          if (q.ld_active && q.ld_row <= 7'(NUM_POINTS))
          begin
            np = q.stg[q.ld_row];
            hv = {q.ld_ext, pwdata};
            case (q.ld_col)
              3'd0: begin ok = pwdata <= 32'(NOM_VALUE >> 1); np.ac_s = pwdata[15:0]; end
              3'd1: begin ok = pwdata <= 32'(NOM_VALUE >> 1); np.ac_e = pwdata[15:0]; end
              3'd2: begin ok = pwdata <= FREQ_MAX; np.f_s = pwdata[FREQ_W-1:0]; end
              3'd3: begin ok = pwdata <= FREQ_MAX; np.f_e = pwdata[FREQ_W-1:0]; end
              3'd4: begin ok = pwdata <= PHASE_MAX; np.ph = pwdata[PH_W-1:0]; end
              3'd5: begin ok = pwdata >= 32'(np.ac_s) && pwdata <= 32'(NOM_VALUE - np.ac_s); np.dc_s = pwdata[15:0]; end
              3'd6: begin ok = pwdata >= 32'(np.ac_e) && pwdata <= 32'(NOM_VALUE - np.ac_e); np.dc_e = pwdata[15:0]; end
              3'd7: begin ok = hv >= TIME_MIN_US && hv <= TIME_MAX_US; np.dur = hv; end
              default: ok = 1'b0;
            endcase
            n.stg[q.ld_row] = np;
            if (!ok)
              n.ld_err = 1'b1;
            n.ld_col = q.ld_col + 3'd1;
            if (q.ld_col == 3'd7)
              n.ld_row = q.ld_row + 7'd1;
          end
          else if (q.ld_active)
            n.ld_err = 1'b1;
        end
        default: ;
      endcase
    end
    if (acc && !pwrite && paddr == OFF_EXP_DATA && q.exp_row < 7'(NUM_POINTS))
    begin
      n.exp_col = (q.exp_col == 4'(EXP_COLS - 1)) ? 4'd0 : q.exp_col + 4'd1;
      if (q.exp_col == 4'(EXP_COLS - 1))
        n.exp_row = q.exp_row + 7'd1;
    end
    // Sequencer: snapshot a sample, then advance time and point
    if (q.seq == SQ_RUN && smp)
    begin
      p = q.tbl[q.cur];
      n.go0 = 1'b1;
      n.sp = q.cur;
      n.sn = q.elapsed;
      n.sph = q.phase;
      n.phase = q.phase + 32'(q.freq * PHASE_PER_HZ);
      if (q.elapsed + 36'(SAMPLE_US) >= p.dur)
      begin
        n.elapsed = '0;
        nxt = q.cur + 7'd1;
        if (q.cur == q.pt_last)
        begin
          nxt = q.pt_first;
          n.cyc = q.cyc + 10'd1;
          if (q.cycles != '0 && q.cyc + 10'd1 == q.cycles)
            n.seq = SQ_IDLE;
        end
        n.cur = nxt;
        n.phase = q.tbl[nxt].ph * PHASE_PER_DEG;
        n.freq = q.tbl[nxt].f_s;
      end
      else
        n.elapsed = q.elapsed + 36'(SAMPLE_US);
    end
    if (d0.done)
    begin
      p = q.tbl[q.sp];
      frac = (d0.quo > 17'h10000) ? 17'h10000 : d0.quo;
      amp = lerp(p.ac_s, p.ac_e, frac);
      dcv = lerp(p.dc_s, p.dc_e, frac);
      frv = lerp(16'(p.f_s), 16'(p.f_e), frac);
      if (q.sp == q.cur)
        n.freq = frv[FREQ_W-1:0];
      mag = (p.f_s == '0 && p.f_e == '0) ? 16'd0 : 16'((32'(amp) * 32'(sine_mag(q.sph))) >> 16);
      vs = q.sph[31] ? $signed({2'b00, dcv}) - $signed({2'b00, mag}) : $signed({2'b00, dcv}) + $signed({2'b00, mag});
      if (!q.func_ramp)
        n.set_q = (vs < 0) ? 16'd0 : (vs > $signed({2'b00, NOM_VALUE})) ? NOM_VALUE : vs[15:0];
    end
    // Ramp generator
    unique case (q.ramp)
      RP_IDLE, RP_HOLD: ;
      RP_DELAY:
        if (smp)
        begin
          if (q.r_el + 36'(SAMPLE_US) >= 36'(q.r_delay) * 36'(RAMP_UNIT_US))
          begin
            n.ramp = RP_SLOPE;
            n.r_el = '0;
          end
          else
            n.r_el = q.r_el + 36'(SAMPLE_US);
        end
      RP_SLOPE:
      begin
        if (smp)
        begin
          if (q.r_el + 36'(SAMPLE_US) >= 36'(q.r_dur) * 36'(RAMP_UNIT_US))
          begin
            n.ramp = RP_HOLD;
            n.set_q = q.r_end;
          end
          else
          begin
            n.r_el = q.r_el + 36'(SAMPLE_US);
            n.go1 = 1'b1;
          end
        end
        else if (d1.done)
          n.set_q = lerp(q.r_start, q.r_end, (d1.quo > 17'h10000) ? 17'h10000 : d1.quo);
      end
    endcase
    // Start and stop
    if (wr && paddr == OFF_CTRL && pwdata[CTRL_STOP])
    begin
      n.seq = SQ_IDLE;
      n.ramp = RP_IDLE;
    end
    else if (wr && paddr == OFF_CTRL && pwdata[CTRL_START] && !q.ld_active && !running)
    begin
      if (pwdata[CTRL_RAMP])
      begin
        n.ramp = RP_DELAY;
        n.r_el = '0;
      end
      else
      begin
        n.seq = SQ_RUN;
        n.cur = q.pt_first;
        n.cyc = '0;
        n.elapsed = '0;
        n.phase = q.tbl[q.pt_first].ph * PHASE_PER_DEG;
        n.freq = q.tbl[q.pt_first].f_s;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= n;
  end

  assign d0.start = q.go0;
  assign d0.num = q.sn;
  assign d0.den = q.tbl[q.sp].dur;
  assign d1.start = q.go1;
  assign d1.num = q.r_el;
  assign d1.den = 36'(q.r_dur) * 36'(RAMP_UNIT_US);

  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign set_value = q.set_q;
  assign target_current = q.target_cur;
  assign gen_active = q.seq == SQ_RUN || q.ramp == RP_DELAY || q.ramp == RP_SLOPE;

endmodule : aws_top

// ### tb/aws_top_assertions.sv
// Port checks of the waveform sequencer
module aws_top_assertions import aws_pkg::*; #(
  parameter logic [15:0] NOM_VALUE = 16'hffff
) (
  // Clock and reset
  input logic core_clk,
  input logic rst_n,
  // APB
  input logic [11:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [3:0] pstrb,
  input logic [31:0] prdata,
  input logic pslverr,
  // Source side
  input logic [15:0] set_value,
  input logic target_current,
  input logic gen_active
);
  logic [5:0] idle_q;
  logic [9:0] chg_q;
  logic acc;
  assign acc = psel && penable;
  // Starts saturated, so the first update after a reset is not judged against the reset itself
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      idle_q <= '0;
      chg_q <= '1;
    end
    else
    begin
      idle_q <= gen_active ? 6'h00 : idle_q + 6'(idle_q != 6'h3f);
      chg_q <= $changed(set_value) ? 10'h000 : chg_q + 10'(chg_q != 10'h3ff);
    end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_nom; set_value <= NOM_VALUE; endproperty
  a_nom: assert property (p_nom) else $error("set value above rating");
  property p_tgt; gen_active && $past(gen_active) |-> $stable(target_current); endproperty
  a_tgt: assert property (p_tgt) else $error("target changed while running");
  property p_hold; idle_q > 6'h28 |-> $stable(set_value); endproperty
  a_hold: assert property (p_hold) else $error("set value moved while idle");
  property p_rate; $changed(set_value) |-> chg_q >= 10'h190; endproperty
  a_rate: assert property (p_rate) else $error("set value updated off the sample rate");
  property p_err_acc; pslverr |-> acc; endproperty
  a_err_acc: assert property (p_err_acc) else $error("error outside access");
  property p_unmap; acc && paddr > OFF_SET_VALUE |-> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
  property p_strb; acc && pwrite && pstrb != 4'hf |-> pslverr; endproperty
  a_strb: assert property (p_strb) else $error("partial write not refused");
  property p_rd0; acc && !pwrite && paddr > OFF_SET_VALUE |-> prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("unmapped read data not zero");
  c_run: cover property (gen_active ##1 !gen_active);
  c_err: cover property (acc && pslverr);
  c_chg: cover property ($changed(set_value));
endmodule : aws_top_assertions

bind aws_top aws_top_assertions #(.NOM_VALUE(NOM_VALUE)) i_aws_top_assertions (.core_clk(core_clk), .rst_n(rst_n),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pstrb(pstrb), .prdata(prdata),
  .pslverr(pslverr), .set_value(set_value), .target_current(target_current), .gen_active(gen_active));

// ### tb/aws_top_tb.sv
// Self-checking bench of the waveform sequencer
module aws_top_tb import aws_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, output_on = 0, pready, pslverr, er;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic target_current, gen_active;
  logic [15:0] set_value, sv;
  int num_errors = 0, n_checks = 0, cyc = 0;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic r;} aws_row_s;
  aws_row_s rows[8] = '{
    '{OFF_SEQ_CFG, 32'h0001_0201, 32'h0001_0201, 1'b0},
    '{OFF_SEQ_CFG, 32'h0001_6401, 32'h0001_0201, 1'b0},
    '{OFF_SEQ_CFG, 32'h03e8_0101, 32'h0001_0201, 1'b0},
    '{OFF_SEQ_CFG, 32'h03e7_0101, 32'h03e7_0101, 1'b0},
    '{OFF_RAMP_START, 32'h0000_ffff, 32'h0000_8000, 1'b0},
    '{OFF_RAMP_DELAY, 32'hffff_ffff, RAMP_T_MAX, 1'b0},
    '{OFF_CTRL, 32'h0000_001c, 32'h0000_001c, 1'b0},
    '{12'h03c, 32'h0000_0001, 32'h0000_0000, 1'b1}};
  // Point 1 is a pure DC ramp, so its course is predictable without a sine model
  logic [31:0] pt[8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h100, 32'h300, 32'hc8};
  aws_top #(.NOM_VALUE(16'h8000)) i_aws_top (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .output_on(output_on), .set_value(set_value), .target_current(target_current),
    .gen_active(gen_active));
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  task test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 70000)
    begin
      num_errors++;
      test_done;
    end
  end
  task chk(input logic [35:0] g, input logic [35:0] e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task reset_dut;
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask : reset_dut
  task wait_idle(input int n);
    for (int i = 0; i < n && gen_active !== 1'b0; i++)
      @(posedge core_clk);
  endtask : wait_idle
  initial
  begin
    reset_dut;
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].e);
      chk(er, rows[i].r);
    end
    $display("register table done");
    apb(1'b1, OFF_RAMP_START, 32'h100);
    apb(1'b1, OFF_RAMP_END, 32'h200);
    apb(1'b1, OFF_RAMP_DELAY, 32'h1);
    apb(1'b1, OFF_RAMP_DUR, 32'h2);
    apb(1'b1, OFF_CTRL, 32'h4);
    apb(1'b1, OFF_CTRL, 32'h5);
    // Target and function bits must be ignored while the ramp runs
    apb(1'b1, OFF_CTRL, 32'h8);
    repeat (3000) @(posedge core_clk);
    chk(set_value, 16'h0);
    chk(gen_active, 1'b1);
    chk(target_current, 1'b0);
    wait_idle(20000);
    chk(set_value, 16'h200);
    $display("ramp done");
    pstrb <= 4'h3;
    apb(1'b1, OFF_RAMP_END, 32'h0);
    chk(er, 1'b1);
    pstrb <= 4'hf;
    apb(1'b0, OFF_RAMP_END, 32'h0);
    chk(rd, 32'h200);
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_NAME_LO, CHR_WAVE);
    apb(1'b1, OFF_NAME_HI, 32'h5520);
    apb(1'b1, OFF_LOAD_CTRL, 32'h1);
    apb(1'b1, OFF_LOAD_SEP, 32'h2c3b);
    for (int r = 0; r < 99; r++)
      for (int c = 0; c < 8; c++)
      begin
        if (c == 7)
          apb(1'b1, OFF_LOAD_EXT, 32'h0);
        apb(1'b1, OFF_LOAD_DATA, r > 0 ? (c == 7 ? 32'h64 : 32'h0) : pt[c]);
      end
    apb(1'b1, OFF_LOAD_CTRL, 32'h2);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd[3], 1'b0);
    apb(1'b1, OFF_SEQ_CFG, 32'h0001_0101);
    apb(1'b1, OFF_CTRL, 32'h1);
    repeat (600) @(posedge core_clk);
    chk(set_value inside {[16'h100:16'h140]}, 1'b1);
    sv = set_value;
    repeat (15)
    begin
      repeat (500) @(posedge core_clk);
      chk(set_value >= sv, 1'b1);
      sv = set_value;
    end
    wait_idle(12000);
    chk(set_value inside {[16'h2c0:16'h300]}, 1'b1);
    $display("sequence done");
    @(posedge core_clk) output_on <= 1'b1;
    repeat (4) @(posedge core_clk);
    apb(1'b1, OFF_LOAD_CTRL, 32'h1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd[3], 1'b1);
    @(posedge core_clk) output_on <= 1'b0;
    repeat (4) @(posedge core_clk);
    apb(1'b1, OFF_LOAD_CTRL, 32'h4);
    for (int c = 0; c < 9; c++)
    begin
      apb(1'b0, OFF_EXP_DATA, 32'h0);
      chk(rd, c < 8 ? pt[c] : 32'h0);
    end
    $display("refused import done");
    // Endless block: past one full cycle it must restart low, then stop on request
    apb(1'b1, OFF_SEQ_CFG, 32'h0000_0101);
    apb(1'b1, OFF_CTRL, 32'h1);
    repeat (12000) @(posedge core_clk);
    chk(gen_active, 1'b1);
    chk(set_value < 16'h200, 1'b1);
    apb(1'b1, OFF_CTRL, 32'h3);
    @(posedge core_clk);
    chk(gen_active, 1'b0);
    $display("endless run done");
    reset_dut;
    apb(1'b0, OFF_SEQ_CFG, 32'h0);
    chk(rd, 32'h0000_0101);
    chk(set_value, 16'h0);
    $display("second reset done");
    test_done;
  end
endmodule : aws_top_tb
